// file: efmp_pkg.sv
// Constants and types for the encoder frequency and period measurement
package efmp_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned NS_PER_US = 1000;
    localparam int unsigned NS_PER_MS = 1000000;
    localparam int unsigned NS_PER_S = 1000000000;

    // Timebase ticks per unit of time
    localparam logic [31:0] CYC_PER_US = 32'(NS_PER_US / CLK_PERIOD_NS);
    localparam logic [39:0] CYC_PER_MS = 40'(NS_PER_MS / CLK_PERIOD_NS);
    localparam logic [63:0] TS_PER_S = 64'(NS_PER_S / CLK_PERIOD_NS);

    // Numerator factors: ticks per second times output units per hertz
    localparam logic [63:0] HZ_NUM_COARSE = TS_PER_S;
    localparam logic [63:0] HZ_NUM_FINE = 64'(TS_PER_S * 64'h64);

    // Frequency window, reset length 10 ms, held in microseconds
    localparam int unsigned FREQ_WINDOW_RST_MS = 10;
    localparam logic [15:0] FREQ_WINDOW_RST_US =
        16'(FREQ_WINDOW_RST_MS * 1000);

    localparam logic [15:0] FREQ_SCALE_1HZ = 16'h0001;
    localparam logic [15:0] FREQ_SCALE_RST = 16'h0064;
    localparam logic [15:0] FREQ_WAIT_RST_MS = 16'h0640;

    localparam logic [15:0] PER_SCALE_RST = 16'h000A;
    localparam logic [15:0] PER_SCALE_100NS = 16'h0064;
    localparam logic [15:0] PER_SCALE_500NS = 16'h01F4;
    localparam logic [31:0] PER_DIV_100NS = 32'h0000000A;
    localparam logic [31:0] PER_DIV_500NS = 32'h00000032;

    // Period timeout 21 s and the value shown after it
    localparam int unsigned PER_TIMEOUT_S = 21;
    localparam logic [31:0] PER_TIMEOUT_CYC_DEF =
        32'(64'(PER_TIMEOUT_S) * TS_PER_S);
    localparam logic [31:0] PER_MAX = 32'h80000000;

    localparam logic [6:0] DIV_LAST_STEP = 7'h3F;

    typedef struct packed {
        logic [15:0] window_us;
        logic [15:0] freq_scale;
        logic [15:0] per_scale;
        logic [15:0] wait_ms;
    } efmp_cfg_t;
endpackage

// file: efmp_div.sv
// Sequential 64 by 32 bit divider with saturated 32-bit quotient
`timescale 1ns/1ns
`default_nettype none
module efmp_div (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [63:0] num,
    input wire logic [31:0] den,
    output logic busy,
    output logic done,
    output logic [31:0] quo
);
    typedef enum logic {DV_IDLE, DV_RUN} efmp_dv_state_t;

    efmp_dv_state_t state_ff;
    logic [6:0] step_ff;
    logic [63:0] num_ff;
    logic [31:0] rem_ff;
    logic [31:0] den_ff;
    logic [32:0] trial;
    logic fits;
    logic [63:0] nxt_num;

    assign busy = (state_ff == DV_RUN);
    assign trial = {rem_ff, num_ff[63]};
    assign fits = (trial >= {1'b0, den_ff});
    assign nxt_num = {num_ff[62:0], fits};

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff <= DV_IDLE;
        end else begin
            unique case (state_ff)
                DV_IDLE: if (start) state_ff <= DV_RUN;
                DV_RUN: if (step_ff == efmp_pkg::DIV_LAST_STEP)
                    state_ff <= DV_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            step_ff <= 7'h00;
            num_ff <= 64'h0;
            rem_ff <= 32'h0;
            den_ff <= 32'h0;
        end else if (!busy && start) begin
            step_ff <= 7'h00;
            num_ff <= num;
            rem_ff <= 32'h0;
            den_ff <= den;
        end else if (busy) begin
            step_ff <= step_ff + 7'h01;
            num_ff <= nxt_num;
            rem_ff <= fits ? 32'(trial - {1'b0, den_ff}) : trial[31:0];
        end
    end

    // Quotient wider than 32 bits (or zero divisor) saturates
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            done <= 1'b0;
            quo <= 32'h0;
        end else begin
            done <= busy && (step_ff == efmp_pkg::DIV_LAST_STEP);
            if (busy && (step_ff == efmp_pkg::DIV_LAST_STEP)) begin
                quo <= (|nxt_num[63:32]) ? 32'hFFFFFFFF : nxt_num[31:0];
            end
        end
    end
endmodule
`default_nettype wire

// file: efmp_measure.sv
// One channel of track-A frequency and period measurement
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Frequency is complete track-A periods divided by measured time.
// - Periods are counted in the window from its first rising edge.
// - Time runs from first rising to last falling edge, in 10 ns ticks.
// - The window setting resets to 10 ms.
// - Frequency is in 0.01 Hz, or in 1 Hz when its scaling is 1.
// - Frequency windows run free of the control cycle and mode.
// - Counter gate or external reset does not touch the frequency.
// - Empty windows retry until wait time, holding the last value.
// - No period before the wait time ends gives frequency zero.
// - Period is the time between successive rising edges, 10 ns ticks.
// - Each control cycle shows the last period completed in it.
// - Period is in 10 ns, or 100 ns or 500 ns for scaling 100 or 500.
// - With no new period in a control cycle the last value is held.
// - Period timing spans cycles and the output updates on completion.
// - No rising edge within 21 s of the last one sets the period output to 2147483648.
module efmp_measure #(
    parameter logic [31:0] PER_TIMEOUT_CYC = efmp_pkg::PER_TIMEOUT_CYC_DEF
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic track_a,
    input wire logic cycle_tick,
    input wire logic cfg_wr,
    input wire efmp_pkg::efmp_cfg_t cfg_in,
    output var efmp_pkg::efmp_cfg_t cfg_out,
    output logic [31:0] frequency_value_out,
    output logic [31:0] period_value_out,
    output logic period_new
);
    function automatic logic [63:0] freq_num(
        input logic [31:0] periods,
        input logic [15:0] scale
    );
        if (scale == efmp_pkg::FREQ_SCALE_1HZ) begin
            freq_num = 64'(64'(periods) * efmp_pkg::HZ_NUM_COARSE);
        end else begin
            freq_num = 64'(64'(periods) * efmp_pkg::HZ_NUM_FINE);
        end
    endfunction

    function automatic logic [31:0] per_scaled(
        input logic [31:0] ticks,
        input logic [15:0] scale
    );
        unique case (scale)
            efmp_pkg::PER_SCALE_100NS:
                per_scaled = ticks / efmp_pkg::PER_DIV_100NS;
            efmp_pkg::PER_SCALE_500NS:
                per_scaled = ticks / efmp_pkg::PER_DIV_500NS;
            default: per_scaled = ticks;
        endcase
    endfunction

    efmp_pkg::efmp_cfg_t cfg_ff;
    logic a_s1_ff;
    logic a_s2_ff;
    logic a_s3_ff;
    logic rise_p;
    logic fall_p;
    logic [31:0] ts_ff;

    logic [31:0] win_cyc;
    logic [31:0] win_cnt_ff;
    logic win_end;
    logic started_ff;
    logic [31:0] t0_ff;
    logic [31:0] t_fall_ff;
    logic [31:0] rise_cnt_ff;
    logic [31:0] periods_ff;
    logic [39:0] wait_cyc;
    logic [39:0] wait_cnt_ff;
    logic wait_hit;
    logic div_start;
    logic div_busy;
    logic div_done;
    logic [31:0] div_quo;

    logic [31:0] per_cnt_ff;
    logic per_armed_ff;
    logic per_upd;
    logic per_to;

    assign cfg_out = cfg_ff;

    // Settings load on a write strobe and reset to their defaults
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg_ff.window_us <= efmp_pkg::FREQ_WINDOW_RST_US;
            cfg_ff.freq_scale <= efmp_pkg::FREQ_SCALE_RST;
            cfg_ff.per_scale <= efmp_pkg::PER_SCALE_RST;
            cfg_ff.wait_ms <= efmp_pkg::FREQ_WAIT_RST_MS;
        end else if (cfg_wr) begin
            cfg_ff <= cfg_in;
        end
    end

    // Track A is asynchronous: two stages, then a third for edges
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            a_s1_ff <= 1'b0;
            a_s2_ff <= 1'b0;
            a_s3_ff <= 1'b0;
        end else begin
            a_s1_ff <= track_a;
            a_s2_ff <= a_s1_ff;
            a_s3_ff <= a_s2_ff;
        end
    end

    assign rise_p = a_s2_ff && !a_s3_ff;
    assign fall_p = !a_s2_ff && a_s3_ff;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ts_ff <= 32'h0;
        end else begin
            ts_ff <= ts_ff + 32'h1;
        end
    end

    // Frequency windows run back to back, with no control-cycle or gate
    // input anywhere in this path
    assign win_cyc = 32'(32'(cfg_ff.window_us) * efmp_pkg::CYC_PER_US);
    assign win_end = (win_cnt_ff + 32'h1 >= win_cyc);

    always_ff @(posedge clk) begin
        if (!rst_b || win_end) begin
            win_cnt_ff <= 32'h0;
        end else begin
            win_cnt_ff <= win_cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || win_end) begin
            started_ff <= 1'b0;
            t0_ff <= 32'h0;
            rise_cnt_ff <= 32'h0;
            t_fall_ff <= 32'h0;
            periods_ff <= 32'h0;
        end else begin
            if (rise_p) begin
                if (!started_ff) begin
                    started_ff <= 1'b1;
                    t0_ff <= ts_ff;
                    rise_cnt_ff <= 32'h1;
                end else begin
                    rise_cnt_ff <= rise_cnt_ff + 32'h1;
                end
            end
            if (fall_p && rise_cnt_ff >= 32'h2) begin
                t_fall_ff <= ts_ff;
                periods_ff <= rise_cnt_ff - 32'h1;
            end
        end
    end

    assign div_start = win_end && (periods_ff != 32'h0) && !div_busy;
    assign wait_cyc = 40'(40'(cfg_ff.wait_ms) * efmp_pkg::CYC_PER_MS);
    assign wait_hit = (wait_cnt_ff + 40'h1 >= wait_cyc);

    // Time since the last window that held a complete period, or since the wait time last ran out
    always_ff @(posedge clk) begin
        if (!rst_b || div_start || wait_hit) begin
            wait_cnt_ff <= 40'h0;
        end else begin
            wait_cnt_ff <= wait_cnt_ff + 40'h1;
        end
    end

    efmp_div u_div (
        .clk(clk),
        .rst_b(rst_b),
        .start(div_start),
        .num(freq_num(periods_ff, cfg_ff.freq_scale)),
        .den(t_fall_ff - t0_ff),
        .busy(div_busy),
        .done(div_done),
        .quo(div_quo)
    );

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            frequency_value_out <= 32'h0;
        end else if (div_done) begin
            frequency_value_out <= div_quo;
        end else if (wait_hit) begin
            frequency_value_out <= 32'h0;
        end
    end

    // Period timing runs across control cycles
    assign per_upd = rise_p && per_armed_ff;
    assign per_to = per_armed_ff && !rise_p &&
        (per_cnt_ff >= PER_TIMEOUT_CYC);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            per_cnt_ff <= 32'h0;
        end else if (rise_p) begin
            per_cnt_ff <= 32'h1;
        end else if (per_armed_ff && !per_to) begin
            per_cnt_ff <= per_cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            per_armed_ff <= 1'b0;
        end else if (rise_p) begin
            per_armed_ff <= 1'b1;
        end else if (per_to) begin
            per_armed_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            period_value_out <= 32'h0;
        end else if (per_upd) begin
            period_value_out <= per_scaled(per_cnt_ff,
                cfg_ff.per_scale);
        end else if (per_to) begin
            period_value_out <= efmp_pkg::PER_MAX;
        end
    end

    // Marks a fresh period in the current control cycle; set wins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            period_new <= 1'b0;
        end else if (per_upd) begin
            period_new <= 1'b1;
        end else if (cycle_tick) begin
            period_new <= 1'b0;
        end
    end

    a_win_default: assert property (@(posedge clk)
        !rst_b |=> cfg_ff.window_us == efmp_pkg::FREQ_WINDOW_RST_US)
        else $error("window setting not at default after reset");

    a_count_start: assert property (
        @(posedge clk) disable iff (!rst_b)
        rise_p && !started_ff && !win_end |=>
        started_ff && t0_ff == $past(ts_ff) && rise_cnt_ff == 32'h1)
        else $error("first rising edge not captured");

    a_fall_mark: assert property (
        @(posedge clk) disable iff (!rst_b)
        fall_p && rise_cnt_ff >= 32'h2 && !win_end |=>
        t_fall_ff == $past(ts_ff) && periods_ff == $past(rise_cnt_ff) - 1)
        else $error("falling edge time or period count wrong");

    a_win_restart: assert property (
        @(posedge clk) disable iff (!rst_b)
        win_end |=> win_cnt_ff == 32'h0 && !started_ff &&
        periods_ff == 32'h0)
        else $error("window state not cleared at window end");

    a_freq_divide: assert property (
        @(posedge clk) disable iff (!rst_b)
        div_start |=> div_busy [*8])
        else $error("divider not running after window end");

    a_freq_result: assert property (
        @(posedge clk) disable iff (!rst_b)
        div_done |=> frequency_value_out == $past(div_quo))
        else $error("frequency not taken from divider");

    a_freq_hold: assert property (
        @(posedge clk) disable iff (!rst_b)
        !div_done && !wait_hit |=> $stable(frequency_value_out))
        else $error("frequency changed without a result");

    a_freq_zero: assert property (
        @(posedge clk) disable iff (!rst_b)
        wait_hit && !div_done |=> frequency_value_out == 32'h0)
        else $error("frequency not zero after wait time");

    a_period_meas: assert property (
        @(posedge clk) disable iff (!rst_b)
        per_upd |=> period_value_out ==
        per_scaled($past(per_cnt_ff), $past(cfg_ff.per_scale)))
        else $error("period value wrong");

    a_period_hold: assert property (
        @(posedge clk) disable iff (!rst_b)
        !per_upd && !per_to |=> $stable(period_value_out))
        else $error("period changed without a measurement");

    a_period_flag: assert property (
        @(posedge clk) disable iff (!rst_b)
        per_upd |=> period_new and (!cycle_tick |=> period_new))
        else $error("new period flag lost");

    a_flag_clear: assert property (
        @(posedge clk) disable iff (!rst_b)
        cycle_tick && !per_upd |=> !period_new)
        else $error("new period flag not cleared by control cycle");

    a_period_timeout: assert property (
        @(posedge clk) disable iff (!rst_b)
        per_to |=> period_value_out == efmp_pkg::PER_MAX && !per_armed_ff)
        else $error("period timeout not flagged");

    a_period_rearm: assert property (
        @(posedge clk) disable iff (!rst_b)
        rise_p && !per_armed_ff |=>
        per_armed_ff && $stable(period_value_out))
        else $error("rising edge after timeout gave a period value");
endmodule
`default_nettype wire

// file: efmp_track_model.sv
// Behavioural encoder track A source for the measurement bench
`timescale 1ns/1ns
`default_nettype none
module efmp_track_model (
    output var logic track_a
);
    initial track_a = 1'b0;

    // Whole periods, each opened by a rising edge; the line idles low
    task automatic pulses(input int n, input int hi, input int lo);
        #3;
        for (int i = 0; i < n; i++) begin
            track_a = 1'b1;
            #(hi * 10);
            track_a = 1'b0;
            #(lo * 10);
        end
    endtask
endmodule
`default_nettype wire

// file: encoder_freq_period_measure_tb.sv
// Self-checking testbench for the encoder frequency and period measurement
`timescale 1ns/1ns
`default_nettype none
module encoder_freq_period_measure_tb;
    localparam logic [31:0] TO_CYC = 32'h000007D0;
    localparam logic [31:0] PMAX = 32'h80000000;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cycle_tick = 1'b0;
    logic cfg_wr = 1'b0;
    efmp_pkg::efmp_cfg_t cfg_in = '0;
    efmp_pkg::efmp_cfg_t cfg_out;
    logic track_a;
    logic [31:0] frequency_value_out;
    logic [31:0] period_value_out;
    logic period_new;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    int seed = 3;
    int p;
    logic [31:0] q_per[$];
    logic [31:0] q_frq[$];
    logic [31:0] last_per = '0;
    logic [31:0] last_frq = '0;
    logic [31:0] exp_v;
    logic [15:0] scales[3] = '{16'h000A, 16'h0064, 16'h01F4};
    int divs[3] = '{1, 10, 50};

    efmp_measure #(.PER_TIMEOUT_CYC(TO_CYC)) uut (
        .clk(clk),
        .rst_b(rst_b),
        .track_a(track_a),
        .cycle_tick(cycle_tick),
        .cfg_wr(cfg_wr),
        .cfg_in(cfg_in),
        .cfg_out(cfg_out),
        .frequency_value_out(frequency_value_out),
        .period_value_out(period_value_out),
        .period_new(period_new)
    );

    efmp_track_model trk (
        .track_a(track_a)
    );

    always #5 clk = ~clk;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic set_cfg(input logic [15:0] fs, input logic [15:0] ps,
                           input logic [15:0] wt);
        @(negedge clk);
        cfg_in = {16'h0002, fs, ps, wt};
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
        chk("settings", 64'(cfg_out), {16'h0002, fs, ps, wt});
    endtask

    // Three rises 40 cycles apart placed inside one 200-cycle window
    task automatic freq_burst(input logic [31:0] exp);
        while (cyc % 200 != 50) @(negedge clk);
        q_frq.push_back(exp);
        q_per.push_back(32'h00000028);
        q_per.push_back(PMAX);
        trk.pulses(3, 20, 20);
        cycles(2400);
        chk("frequency pending", 64'(q_frq.size()), 64'h0);
        $display("test frequency %0h done", exp);
    endtask

    always @(posedge clk) begin
        cyc <= rst_b ? cyc + 1 : 0;
        if (cyc > 30000) begin
            err_count++;
            report_and_stop();
        end
    end

    always @(negedge clk) begin
        cycle_tick <= (cyc % 50 == 49);
    end

    // Scoreboard: each output change consumes the oldest note
    always @(negedge clk) begin
        if (rst_b && period_value_out !== last_per) begin
            exp_v = q_per.size() ? q_per.pop_front() : last_per;
            last_per = period_value_out;
            chk("period", 64'(period_value_out), 64'(exp_v));
            if (exp_v !== PMAX) begin
                chk("period flag", 64'(period_new), 64'h1);
            end
        end
        if (rst_b && frequency_value_out !== last_frq) begin
            exp_v = q_frq.size() ? q_frq.pop_front() : last_frq;
            last_frq = frequency_value_out;
            chk("frequency", 64'(frequency_value_out), 64'(exp_v));
        end
    end

    initial begin
        cycles(6);
        rst_b = 1'b1;
        chk("reset settings", 64'(cfg_out), {16'h2710,
            efmp_pkg::FREQ_SCALE_RST, efmp_pkg::PER_SCALE_RST,
            efmp_pkg::FREQ_WAIT_RST_MS});
        chk("reset outputs", {frequency_value_out, period_value_out},
            64'h0);
        set_cfg(16'h0064, 16'h000A, efmp_pkg::FREQ_WAIT_RST_MS);
        freq_burst(32'h0BEBC200);
        set_cfg(16'h0001, 16'h000A, efmp_pkg::FREQ_WAIT_RST_MS);
        freq_burst(32'h001E8480);
        for (int i = 0; i < 3; i++) begin
            p = 50 * (10 + ($random(seed) & 7));
            set_cfg(16'h0001, scales[i], efmp_pkg::FREQ_WAIT_RST_MS);
            q_per.push_back(32'(p / divs[i]));
            q_per.push_back(PMAX);
            trk.pulses(2, p / 2, p / 2);
            cycles(2400);
            chk("period pending", 64'(q_per.size()), 64'h0);
            chk("flag after ticks", 64'(period_new), 64'h0);
            $display("test period %0d scale %0d done", p, scales[i]);
        end
        q_frq.push_back(32'h0);
        set_cfg(16'h0001, 16'h000A, 16'h0000);
        cycles(5);
        chk("frequency zeroed", 64'(q_frq.size()), 64'h0);
        $display("test wait time done");
        report_and_stop();
    end
endmodule
`default_nettype wire
